// file: hw/cwf_top.sv
// Configuration word bank: flash load, write-once registers, AXI4-Lite slave and option decode
`default_nettype none
module cwf_top
	import cwf_pkg::*;
#(
	parameter int FLASH_KB   = FLASH_KB_FULL,
	parameter int WDOG_CYC   = WDOG_BASE_CYC
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire cwf_axi_req_t     axi_req,
	output var  cwf_axi_rsp_t     axi_rsp,
	input  wire cwf_flash_words_t flash_config_words,
	input  wire logic             timer1_osc_en,
	input  wire logic             pin_unlock_done,
	input  wire logic             pin_lock_set_req,
	input  wire logic             pin_lock_clr_req,
	input  wire logic [5:0]       flash_page_query,
	input  wire logic             ds_ref_tick,
	output var  cwf_options_t     options,
	output logic                  secondary_clk_allowed,
	output logic [15:0]           wdog_ratio,
	output logic [31:0]           ds_wdog_ratio,
	output logic                  wdog_base_tick,
	output logic                  ds_base_tick,
	output logic                  pin_select_lock,
	output logic                  pin_map_write_allow,
	output logic                  page_protected,
	output logic                  load_done
);
	localparam logic [23:0] IDX_LAST  = IDX_PROT_DIS;
	localparam logic [7:0]  IMPL_MASK [NREG] = '{MASK_OSC_LOW, MASK_WDOG_PS, MASK_DEEP_SLEEP,
		MASK_PERIPH_OPT, MASK_FLASH_PROT, MASK_PROT_DIS};
	localparam logic [5:0]  CFG_PAGE  = 6'(FLASH_KB * 1024 / FLASH_PAGE_BYTES - 1);
	localparam logic [5:0]  BOUND_MSK = {FLASH_KB != FLASH_KB_32,
		(FLASH_KB != FLASH_KB_32) && (FLASH_KB != FLASH_KB_16), 4'hf};
	localparam logic [15:0] WDOG_LAST = 16'(WDOG_CYC - 1);
	localparam logic [4:0]  DSW_LAST  = 5'(DSW_PRESCALE - 1);

	// Address decode, shared by both channels
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] >= IDX_OSC_LOW) && (a[ADDR_W-1:2] <= IDX_LAST);
	endfunction
	function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
		return 3'(a[ADDR_W-1:2] - IDX_OSC_LOW);
	endfunction

	cwf_state_t        state_q;
	logic [7:0]        cfg_q [NREG];
	logic [7:0]        cfg_d [NREG];
	logic [NREG-1:0]   written_q;
	logic [NREG-1:0]   written_d;
	logic              aw_got_q;
	logic              w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0]        wbyte_q;
	logic              wlane_q;
	logic              lock_q;
	logic              lock_used_q;
	logic [15:0]       wdog_cnt_q;
	logic [4:0]        dsw_cnt_q;
	cwf_axi_rsp_t      rsp_d;

	// Write channel: address and data taken in either order
	wire               run      = (state_q == ST_RUN);
	wire               aw_fire  = axi_req.awvalid & axi_rsp.awready;
	wire               w_fire   = axi_req.wvalid & axi_rsp.wready;
	wire               have_aw  = aw_got_q | aw_fire;
	wire               have_w   = w_got_q | w_fire;
	wire               do_write = have_aw & have_w;
	wire [ADDR_W-1:0]  wr_addr  = aw_fire ? axi_req.awaddr : awaddr_q;
	wire [7:0]         wr_byte  = w_fire ? axi_req.wdata[7:0] : wbyte_q;
	wire               wr_lane  = w_fire ? axi_req.wstrb[0] : wlane_q;
	wire               wr_hit   = reg_hit(wr_addr);
	wire [2:0]         wr_idx   = reg_idx(wr_addr);
	wire               aw_got_d = have_aw & ~do_write;
	wire               w_got_d  = have_w & ~do_write;
	wire               bvalid_d = do_write | (axi_rsp.bvalid & ~axi_req.bready);
	// Read channel: one read in flight
	wire               ar_fire  = axi_req.arvalid & axi_rsp.arready;
	wire               rd_hit   = reg_hit(axi_req.araddr);
	wire [2:0]         rd_idx   = reg_idx(axi_req.araddr);
	wire               rvalid_d = ar_fire | (axi_rsp.rvalid & ~axi_req.rready);

	always_comb begin
		rsp_d         = axi_rsp;
		rsp_d.bvalid  = bvalid_d;
		rsp_d.awready = run & ~aw_got_d & ~bvalid_d;
		rsp_d.wready  = run & ~w_got_d & ~bvalid_d;
		rsp_d.rvalid  = rvalid_d;
		rsp_d.arready = run & ~rvalid_d;
		if (do_write) begin
			rsp_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (ar_fire) begin
			rsp_d.rdata = rd_hit ? {24'h0, cfg_q[rd_idx]} : 32'h0;
			rsp_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Per-register next value: load once, then a single accepted write; later writes are dropped
	generate
		for (genvar i = 0; i < NREG; i++) begin : g_reg
			wire [7:0] flash_byte = flash_config_words[8*(NREG-1-i) +: 8];
			wire       wr_this    = run & do_write & wr_hit & wr_lane & (wr_idx == 3'(i)) & ~written_q[i];
			assign cfg_d[i]     = ~run ? (flash_byte & IMPL_MASK[i]) :
				wr_this ? (wr_byte & IMPL_MASK[i]) : cfg_q[i];
			assign written_d[i] = written_q[i] | wr_this;
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					cfg_q[i] <= RESET_BYTE & IMPL_MASK[i];
				end else begin
					cfg_q[i] <= cfg_d[i];
				end
			end
		end
	endgenerate

	// Bus state and the load sequencer; the bank leaves load after one edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q   <= ST_LOAD;
			written_q <= '0;
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			awaddr_q  <= '0;
			wbyte_q   <= 8'h0;
			wlane_q   <= 1'b0;
			axi_rsp   <= '0;
			load_done <= 1'b0;
		end else begin
			state_q   <= ST_RUN;
			written_q <= written_d;
			aw_got_q  <= aw_got_d;
			w_got_q   <= w_got_d;
			awaddr_q  <= aw_fire ? axi_req.awaddr : awaddr_q;
			wbyte_q   <= w_fire ? axi_req.wdata[7:0] : wbyte_q;
			wlane_q   <= w_fire ? axi_req.wstrb[0] : wlane_q;
			axi_rsp   <= rsp_d;
			load_done <= run;
		end
	end

	// Option fields, named from the bank
	wire [7:0]  osc_b   = cfg_q[0];
	wire [7:0]  ds_b    = cfg_q[2];
	wire [2:0]  osc_sel = osc_b[OSC_SEL_LSB +: 3];
	wire [3:0]  wdog_ps = cfg_q[1][WDOG_PS_LSB +: 4];
	wire [3:0]  dsw_ps  = ds_b[DSW_PS_LSB +: 4];
	wire        one_way = cfg_q[3][ONE_WAY_BIT];
	wire [7:0]  prot_b  = cfg_q[4];
	wire        prot_off = cfg_q[5][PROT_DIS_BIT];
	cwf_options_t opt_d;

	// Oscillator decode: crystal codes use both pins; odd codes other than OSC_XTAL_PLL and both external codes drive clock out
	always_comb begin
		opt_d                         = '0;
		opt_d.two_speed_startup_en    = osc_b[TWO_SPEED_BIT];
		opt_d.clock_monitor_en        = osc_b[CLK_MON_BIT];
		opt_d.timer1_osc_power_sel    = osc_b[T1_POWER_BIT];
		opt_d.secondary_clk_force_sel = osc_b[SEC_FORCE_BIT];
		opt_d.osc_select              = cwf_osc_t'(osc_sel);
		opt_d.ext_clock_sel           = (osc_sel == OSC_EXT_CLOCK_OUT_FN) || (osc_sel == OSC_EXT_PLL_CLOCK_OUT_FN);
		opt_d.crystal_sel             = (osc_sel == OSC_XTAL) || (osc_sel == OSC_XTAL_PLL);
		opt_d.internal_osc_sel        = ~osc_sel[2];
		opt_d.pll_sw_ctrl             = (osc_sel == OSC_EXT_PLL_CLOCK_OUT_FN) || (osc_sel == OSC_XTAL_PLL) ||
			(osc_sel == OSC_INT_PLL_CLOCK_OUT_FN) || (osc_sel == OSC_INT_PLL);
		opt_d.clock_out_fn            = (osc_sel[0] & (osc_sel != OSC_XTAL_PLL)) |
			(osc_sel == OSC_EXT_CLOCK_OUT_FN);
		opt_d.osc_in_pin_port         = ~osc_sel[2];
		opt_d.osc_out_pin_port        = ~osc_sel[2] & ~osc_sel[0];
		opt_d.deep_sleep_wdog_en      = ds_b[DSW_EN_BIT];
		opt_d.deep_sleep_brownout_en  = ds_b[DS_BOR_BIT];
		opt_d.rtc_ref_clk_sel         = ds_b[RTC_REF_BIT];
		opt_d.deep_sleep_wdog_clk_sel = ds_b[DSW_CLK_BIT];
		opt_d.serial_addr_mask_width  = cfg_q[3][ADDR_MASK_BIT];
	end

	// Pin-select lock: one-way mode refuses a clear and a second set
	wire lock_set_ok = pin_unlock_done & pin_lock_set_req & ~(one_way & lock_used_q);
	wire lock_clr_ok = pin_unlock_done & pin_lock_clr_req & ~one_way;
	wire lock_d      = lock_set_ok | (lock_q & ~lock_clr_ok);

	// Flash protection; boundary bits 5 and 4 read as zero here on 32 KB parts, only bit 4 on 16 KB parts
	wire [5:0] bound    = prot_b[BOUND_LSB +: 6] & BOUND_MSK;
	wire       cfg_hit  = (flash_page_query == CFG_PAGE) & ~prot_b[PROT_CFG_BIT];
	wire       reg_prot = prot_b[PROT_DIR_BIT] ? (flash_page_query >= bound) : (flash_page_query <= bound);
	wire       prot_d   = ~prot_off & (cfg_hit | reg_prot);

	// Timebases: watchdog base counted in sys_clk cycles, deep-sleep prescale of reference ticks
	wire wdog_wrap = (wdog_cnt_q == WDOG_LAST);
	wire dsw_wrap  = ds_ref_tick & (dsw_cnt_q == DSW_LAST);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			options               <= '0;
			secondary_clk_allowed <= 1'b0;
			wdog_ratio            <= 16'h0;
			ds_wdog_ratio         <= 32'h0;
			lock_q                <= 1'b0;
			lock_used_q           <= 1'b0;
			pin_select_lock       <= 1'b0;
			pin_map_write_allow   <= 1'b0;
			page_protected        <= 1'b0;
			wdog_cnt_q            <= 16'h0;
			dsw_cnt_q             <= 5'h0;
			wdog_base_tick        <= 1'b0;
			ds_base_tick          <= 1'b0;
		end else begin
			options               <= opt_d;
			secondary_clk_allowed <= osc_b[SEC_FORCE_BIT] | timer1_osc_en;
			wdog_ratio            <= 16'h1 << wdog_ps;
			ds_wdog_ratio         <= 32'h2 << {dsw_ps, 1'b0};
			lock_q                <= lock_d;
			lock_used_q           <= lock_used_q | lock_set_ok;
			pin_select_lock       <= lock_d;
			pin_map_write_allow   <= ~lock_d;
			page_protected        <= prot_d;
			wdog_cnt_q            <= wdog_wrap ? 16'h0 : wdog_cnt_q + 16'h1;
			dsw_cnt_q             <= ds_ref_tick ? (dsw_wrap ? 5'h0 : dsw_cnt_q + 5'h1) : dsw_cnt_q;
			wdog_base_tick        <= wdog_wrap;
			ds_base_tick          <= dsw_wrap;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// Bus answers come one cycle after the taking edge
	a_write_answer: assert property (do_write |=> axi_rsp.bvalid) else $error("write not answered");
	a_read_answer: assert property (ar_fire |=> axi_rsp.rvalid) else $error("read not answered");
	a_upper_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0) else $error("upper bits set");
	// Register 0, once written, never changes again until reset
	a_write_once: assert property (written_q[0] |=> $stable(cfg_q[0])) else $error("register rewritten");
	a_load_once: assert property (run |=> run) else $error("bank reloaded");
	a_lock_oneway: assert property (one_way && lock_q |=> lock_q && !pin_map_write_allow) else $error("lock cleared");
	a_lock_reuse: assert property (!one_way && lock_q && pin_unlock_done && pin_lock_clr_req && !pin_lock_set_req
		|=> !pin_select_lock) else $error("lock not cleared");
	a_prot_off: assert property (prot_off && $past(prot_off) |-> !page_protected) else $error("protected when off");
	a_crystal_pll: assert property (options.crystal_sel |-> !options.clock_out_fn && !options.internal_osc_sel)
		else $error("crystal decode");
	a_wdog_onehot: assert property (run ##1 run |-> $onehot(wdog_ratio)) else $error("ratio not power of two");
	a_ds_tick_gap: assert property (ds_base_tick |=> !ds_base_tick) else $error("deep sleep tick too close");

	c_write_taken: cover property (do_write && wr_hit && !written_q[wr_idx]);
	c_write_refused: cover property (do_write && wr_hit && written_q[wr_idx]);
	c_read_back: cover property (ar_fire ##1 axi_rsp.rvalid && axi_req.rready);
	c_lock_set: cover property (lock_set_ok && one_way);
endmodule // cwf_top
`default_nettype wire

// file: hw/cwf_pkg.sv
// Package: register map, field layout and types of the configuration word bank
`default_nettype none
package cwf_pkg;
	localparam int          NREG           = 6;
	localparam int          ADDR_W         = 26;
	// Register indexes; byte address is four times the index
	localparam logic [23:0] IDX_OSC_LOW    = 24'h300002;
	localparam logic [23:0] IDX_WDOG_PS    = 24'h300003;
	localparam logic [23:0] IDX_DEEP_SLEEP = 24'h300004;
	localparam logic [23:0] IDX_PERIPH_OPT = 24'h300005;
	localparam logic [23:0] IDX_FLASH_PROT = 24'h300006;
	localparam logic [23:0] IDX_PROT_DIS   = 24'h300007;
	// Implemented bits of each byte, in index order
	localparam logic [7:0]  MASK_OSC_LOW    = 8'hdf;
	localparam logic [7:0]  MASK_WDOG_PS    = 8'h0f;
	localparam logic [7:0]  MASK_DEEP_SLEEP = 8'hff;
	localparam logic [7:0]  MASK_PERIPH_OPT = 8'h09;
	localparam logic [7:0]  MASK_FLASH_PROT = 8'hff;
	localparam logic [7:0]  MASK_PROT_DIS   = 8'h01;
	localparam logic [7:0]  RESET_BYTE      = 8'hff;
	// Field positions
	localparam int TWO_SPEED_BIT = 7;
	localparam int CLK_MON_BIT   = 6;
	localparam int T1_POWER_BIT  = 4;
	localparam int SEC_FORCE_BIT = 3;
	localparam int OSC_SEL_LSB   = 0;
	localparam int WDOG_PS_LSB   = 0;
	localparam int DSW_PS_LSB    = 4;
	localparam int DSW_EN_BIT    = 3;
	localparam int DS_BOR_BIT    = 2;
	localparam int RTC_REF_BIT   = 1;
	localparam int DSW_CLK_BIT   = 0;
	localparam int ADDR_MASK_BIT = 3;
	localparam int ONE_WAY_BIT   = 0;
	localparam int PROT_CFG_BIT  = 7;
	localparam int PROT_DIR_BIT  = 6;
	localparam int BOUND_LSB     = 0;
	localparam int PROT_DIS_BIT  = 0;
	localparam int BOUND_TOP_BIT = 5;
	localparam int BOUND_NXT_BIT = 4;
	// Flash geometry and variants
	localparam int FLASH_PAGE_BYTES = 1024;
	localparam int FLASH_KB_FULL    = 64;
	localparam int FLASH_KB_32      = 32;
	localparam int FLASH_KB_16      = 16;
	// Timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int WDOG_BASE_US    = 4000;
	localparam int WDOG_BASE_CYC   = WDOG_BASE_US * 1000 / CLK_PERIOD_NS;
	localparam int DSW_PRESCALE    = 32;
	localparam int DSW_BASE_US     = 1000;
	// Bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		OSC_INT          = 3'b000,
		OSC_INT_CLOCK_OUT_FN     = 3'b001,
		OSC_INT_PLL      = 3'b010,
		OSC_INT_PLL_CLOCK_OUT_FN = 3'b011,
		OSC_XTAL         = 3'b100,
		OSC_XTAL_PLL     = 3'b101,
		OSC_EXT_CLOCK_OUT_FN     = 3'b110,
		OSC_EXT_PLL_CLOCK_OUT_FN = 3'b111
	} cwf_osc_t;
	typedef enum logic {
		ST_LOAD = 1'b0,
		ST_RUN  = 1'b1
	} cwf_state_t;
	typedef struct packed {
		logic                awvalid;
		logic [ADDR_W-1:0]   awaddr;
		logic                wvalid;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bready;
		logic                arvalid;
		logic [ADDR_W-1:0]   araddr;
		logic                rready;
	} cwf_axi_req_t;
	typedef struct packed {
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} cwf_axi_rsp_t;
	typedef struct packed {
		logic [7:0] osc_low;
		logic [7:0] wdog_ps;
		logic [7:0] deep_sleep;
		logic [7:0] periph_opt;
		logic [7:0] flash_prot;
		logic [7:0] prot_dis;
	} cwf_flash_words_t;
	typedef struct packed {
		logic           two_speed_startup_en;
		logic           clock_monitor_en;
		logic           timer1_osc_power_sel;
		logic           secondary_clk_force_sel;
		cwf_osc_t       osc_select;
		logic           ext_clock_sel;
		logic           crystal_sel;
		logic           internal_osc_sel;
		logic           pll_sw_ctrl;
		logic           clock_out_fn;
		logic           osc_in_pin_port;
		logic           osc_out_pin_port;
		logic           deep_sleep_wdog_en;
		logic           deep_sleep_brownout_en;
		logic           rtc_ref_clk_sel;
		logic           deep_sleep_wdog_clk_sel;
		logic           serial_addr_mask_width;
	} cwf_options_t;
endpackage
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the configuration word bank
`default_nettype none
module tb_top
	import cwf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic             sys_clk;
	logic             reset;
	cwf_axi_req_t     axi_req;
	cwf_axi_rsp_t     axi_rsp;
	cwf_flash_words_t flash_config_words;
	logic             timer1_osc_en;
	logic             pin_unlock_done;
	logic             pin_lock_set_req;
	logic             pin_lock_clr_req;
	logic [5:0]       flash_page_query;
	logic             ds_ref_tick;
	cwf_options_t     options;
	logic             secondary_clk_allowed;
	logic [15:0]      wdog_ratio;
	logic [31:0]      ds_wdog_ratio;
	logic             wdog_base_tick;
	logic             ds_base_tick;
	logic             pin_select_lock;
	logic             pin_map_write_allow;
	logic             page_protected;
	logic             load_done;
	int               miscompares;
	int               n_checks;
	int               n;
	logic [3:0]       c;
	logic [7:0]       exp_reg [6];

	// Short watchdog base count keeps the tick test brief
	cwf_top #(.WDOG_CYC(8)) u_dut (
		.sys_clk, .reset, .axi_req, .axi_rsp, .flash_config_words, .timer1_osc_en,
		.pin_unlock_done, .pin_lock_set_req, .pin_lock_clr_req, .flash_page_query,
		.ds_ref_tick, .options, .secondary_clk_allowed, .wdog_ratio, .ds_wdog_ratio,
		.wdog_base_tick, .ds_base_tick, .pin_select_lock, .pin_map_write_allow,
		.page_protected, .load_done
	);

	// 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic timed_out;
		miscompares++;
		$display("wrong value at %0t ns: wait timed out", $time);
		wrap_up();
	endtask

	function automatic logic [25:0] ba(input logic [23:0] idx);
		return {idx, 2'b00};
	endfunction

	// Reset with new flash contents, then wait until the bank has loaded
	task automatic do_reset(input cwf_flash_words_t w);
		int k;
		k = 0;
		@(posedge sys_clk);
		reset <= 1'b1;
		flash_config_words <= w;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		while (load_done !== 1'b1) begin
			@(posedge sys_clk);
			if (++k > 20) timed_out();
		end
		@(posedge sys_clk);
		#1;
	endtask

	// Address and data offered together; bready held high from the start
	task automatic axi_wr(input logic [25:0] a, input logic [7:0] d, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge sys_clk);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= {24'h0, d};
		axi_req.wstrb <= 4'hf;
		axi_req.bready <= 1'b1;
		forever begin
			@(posedge sys_clk);
			if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
			if (axi_rsp.bvalid) begin
				axi_req.bready <= 1'b0;
				check(32'(axi_rsp.bresp), 32'(er));
				break;
			end
			if (++k > 50) timed_out();
		end
	endtask

	task automatic axi_rd(input logic [25:0] a, input logic [7:0] ed, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge sys_clk);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		axi_req.rready <= 1'b1;
		forever begin
			@(posedge sys_clk);
			if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
			if (axi_rsp.rvalid) begin
				axi_req.rready <= 1'b0;
				check(axi_rsp.rdata, {24'h0, ed});
				check(32'(axi_rsp.rresp), 32'(er));
				break;
			end
			if (++k > 50) timed_out();
		end
	endtask

	task automatic page(input logic [5:0] p, input logic e);
		@(posedge sys_clk);
		flash_page_query <= p;
		repeat (2) @(posedge sys_clk);
		#1;
		check(32'(page_protected), 32'(e));
	endtask

	// One-cycle lock request, then the state a cycle later
	task automatic lk(input logic s, input logic cl, input logic e);
		@(posedge sys_clk);
		pin_lock_set_req <= s;
		pin_lock_clr_req <= cl;
		@(posedge sys_clk);
		pin_lock_set_req <= 1'b0;
		pin_lock_clr_req <= 1'b0;
		@(posedge sys_clk);
		#1;
		check(32'({pin_select_lock, pin_map_write_allow}), 32'({e, !e}));
	endtask

	initial begin
		reset = 1'b1;
		axi_req = '0;
		flash_config_words = '1;
		timer1_osc_en = 1'b0;
		pin_unlock_done = 1'b0;
		pin_lock_set_req = 1'b0;
		pin_lock_clr_req = 1'b0;
		flash_page_query = '0;
		ds_ref_tick = 1'b0;
		miscompares = 0;
		n_checks = 0;
		// Every code of each selector field, one load per code
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			do_reset({c[0], !c[0], 1'b1, c[1], c[2], c[2:0], 4'hf, c, c, c, 4'hf, c[3], 2'b11, c[0], 8'h0a, 8'hf0});
			check(32'(wdog_ratio), 32'(1) << c);
			check(ds_wdog_ratio, 32'(2) << (2 * c));
			check(32'(options.osc_select), 32'(c[2:0]));
			check(32'({options.clock_out_fn, options.pll_sw_ctrl, options.ext_clock_sel, options.crystal_sel}),
				32'({(c[0] && c[2:0] != 3'b101) || c[2:1] == 2'b11, (c[2] && c[0]) || c[2:1] == 2'b01, c[2:1] == 2'b11,
				c[2:1] == 2'b10}));
			check(32'({options.internal_osc_sel, options.osc_in_pin_port, options.osc_out_pin_port}),
				32'({!c[2], !c[2], !c[2] && !c[0]}));
			check(32'({options.two_speed_startup_en, options.clock_monitor_en, options.timer1_osc_power_sel,
				options.secondary_clk_force_sel}), 32'({c[0], !c[0], c[1], c[2]}));
			check(32'({options.deep_sleep_wdog_en, options.deep_sleep_brownout_en, options.rtc_ref_clk_sel,
				options.deep_sleep_wdog_clk_sel}), 32'(c));
			check(32'(options.serial_addr_mask_width), 32'(c[3]));
			axi_rd(ba(IDX_WDOG_PS), {4'h0, c}, RESP_OKAY);
			axi_rd(ba(IDX_DEEP_SLEEP), {c, c}, RESP_OKAY);
		end
		// Loaded bytes read back masked; unused bits read zero
		do_reset({8'hb3, 8'hf5, 8'ha6, 8'hf9, 8'h0a, 8'hf0});
		exp_reg = '{8'h93, 8'h05, 8'ha6, 8'h09, 8'h0a, 8'h00};
		for (int i = 0; i < 6; i++) axi_rd(ba(IDX_OSC_LOW + 24'(i)), exp_reg[i], RESP_OKAY);
		axi_rd(ba(24'h300000), 8'h00, RESP_SLVERR);
		axi_rd(ba(IDX_OSC_LOW) + 26'h1, 8'h00, RESP_SLVERR);
		axi_wr(ba(24'h300010), 8'h00, RESP_SLVERR);
		// Flash edits after load must not reach the bank
		@(posedge sys_clk);
		flash_config_words.wdog_ps <= 8'hf0;
		axi_rd(ba(IDX_WDOG_PS), 8'h05, RESP_OKAY);
		check(32'(wdog_ratio), 32'd32);
		check(32'(secondary_clk_allowed), 32'd0);
		@(posedge sys_clk);
		timer1_osc_en <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check(32'(secondary_clk_allowed), 32'd1);
		// First write takes, the second is ignored
		axi_wr(ba(IDX_OSC_LOW), 8'h48, RESP_OKAY);
		timer1_osc_en <= 1'b0;
		axi_wr(ba(IDX_OSC_LOW), 8'hff, RESP_OKAY);
		axi_rd(ba(IDX_OSC_LOW), 8'h48, RESP_OKAY);
		check(32'({secondary_clk_allowed, options.osc_select}), 32'h8);
		// Protection regions: low side with config page, then high side, then off
		page(6'd10, 1'b1);
		page(6'd11, 1'b0);
		page(6'd63, 1'b1);
		axi_wr(ba(IDX_FLASH_PROT), 8'hc5, RESP_OKAY);
		page(6'd4, 1'b0);
		page(6'd5, 1'b1);
		page(6'd62, 1'b1);
		axi_wr(ba(IDX_PROT_DIS), 8'h01, RESP_OKAY);
		page(6'd5, 1'b0);
		page(6'd63, 1'b0);
		// Pin lock: one-way first, then free toggling
		lk(1'b1, 1'b0, 1'b0);
		@(posedge sys_clk);
		pin_unlock_done <= 1'b1;
		lk(1'b1, 1'b0, 1'b1);
		lk(1'b0, 1'b1, 1'b1);
		axi_wr(ba(IDX_PERIPH_OPT), 8'h08, RESP_OKAY);
		lk(1'b0, 1'b1, 1'b0);
		lk(1'b1, 1'b0, 1'b1);
		lk(1'b0, 1'b1, 1'b0);
		// Watchdog base tick spacing
		n = 0;
		while (wdog_base_tick !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (wdog_base_tick !== 1'b1 && n < 50);
		check(32'(n), 32'd8);
		// 97 reference ticks give three prescaled ticks; the last one shows a cycle after its tick
		n = 0;
		repeat (194) begin
			@(posedge sys_clk);
			ds_ref_tick <= ~ds_ref_tick;
			#1;
			if (ds_base_tick === 1'b1) n++;
		end
		check(32'(n), 32'd3);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
